// File: design/debug_mem_write.sv
// Debug link memory write engine: command decode, lane mapping, fill addressing.
`timescale 1ns/1ps
// Operation
// RL1 - Command 0x11 writes a byte, 0x15 a word, 0x19 a longword.
// RL2 - Three address bytes follow the command, most significant first.
// RL3 - Data bytes follow the address, most significant first, one/two/four.
// RL4 - With-status variant returns the status low byte sampled after the write.
// RL5 - Host waits a delay after the last data byte before reading status.
// RL6 - If enabled, an acknowledge pulse follows write completion or abort.
// RL7 - Longword access zeroes address bits [1:0] and fills all four lanes.
// RL8 - Word access uses two lanes from its offset; offset 11 realigns to 10.
// RL9 - Byte access drives only the lane chosen by address bits [1:0].
// RL10 - Fill address is previous address plus previous access size.
// RL11 - After misaligned longword, fill continues at next 4-byte field.
// RL12 - After realigned word, the original address is incremented.
// RL13 - Word after realigned word continues from it; bytes may repeat.
// RL14 - Stop with debug enabled and clock select set keeps all clocks.
// RL15 - Stop with debug enabled, select clear: only debug serial clock runs.
// RL16 - PC sample gives next instruction address, or the written PC value.
module debug_mem_write #(
   parameter int FIFO_WORDS = debug_mem_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic link_valid,
   input wire logic [7:0] link_data,
   output logic link_ready,
   output logic status_valid,
   output logic [7:0] status_data,
   input wire logic status_ready,
   input wire logic ack_enable,
   output logic ack_pulse,
   output logic bus_req,
   output logic [debug_mem_pkg::ADDR_W-1:0] bus_addr,
   output logic [debug_mem_pkg::DATA_W-1:0] bus_wdata,
   output logic [3:0] bus_be,
   input wire logic bus_done,
   input wire logic bus_abort,
   input wire logic [7:0] debug_status_low_byte,
   input wire logic stop_mode,
   input wire logic debug_enable,
   input wire logic clocks_in_stop_select,
   output logic debug_serial_interface_clock_en,
   output logic bus_clock_en,
   output logic core_clock_en,
   input wire logic active_debug_mode,
   input wire logic [debug_mem_pkg::ADDR_W-1:0] next_pc,
   input wire logic pc_write,
   input wire logic [debug_mem_pkg::ADDR_W-1:0] pc_write_value,
   output logic [debug_mem_pkg::ADDR_W-1:0] pc_sample
);
   import debug_mem_pkg::*;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_DATA = 6'h04,
      ST_BUS = 6'h08,
      ST_SETTLE = 6'h10,
      ST_STATUS = 6'h20
   } state_t;

   state_t state;
   size_t size;
   size_t prev_size;
   logic with_status;
   logic [1:0] count;
   logic [ADDR_W-1:0] addr;
   logic [ADDR_W-1:0] prev_base;
   logic [ADDR_W-1:0] next_fill_addr;
   logic [DATA_W-1:0] data;
   logic [7:0] rx_byte;
   logic rx_valid;
   logic rx_ready;
   logic rx_take;
   logic bus_end;
   logic is_write;
   logic is_write_ws;
   logic is_fill;
   size_t cmd_size;

   lane_map_if lm ();

   // ----------------------------------------------------------------
   // Inbound byte buffer
   // ----------------------------------------------------------------
   // Drained only while collecting bytes, so a host outrunning the bus stalls here.
   byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_WORDS)) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(link_valid),
      .in_data(link_data),
      .in_ready(link_ready),
      .out_valid(rx_valid),
      .out_data(rx_byte),
      .out_ready(rx_ready)
   );

   byte_lane_mapper u_map (
      .lm(lm)
   );

   assign rx_ready = (state == ST_IDLE) || (state == ST_ADDR) || (state == ST_DATA);
   assign rx_take = rx_valid && rx_ready;
   assign bus_end = bus_done || bus_abort;
   assign lm.size = size;
   assign lm.low = addr[1:0];
   assign lm.data = data;

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   always_comb begin
      is_write = 1'b0;
      is_write_ws = 1'b0;
      is_fill = 1'b0;
      cmd_size = SIZE_B;
      case (rx_byte)
         CMD_WRITE_B: is_write = 1'b1; // [RL1]
         CMD_WRITE_W: begin
            is_write = 1'b1;
            cmd_size = SIZE_W;
         end
         CMD_WRITE_L: begin
            is_write = 1'b1;
            cmd_size = SIZE_L;
         end
         CMD_WRITE_WS_B: is_write_ws = 1'b1;
         CMD_WRITE_WS_W: begin
            is_write_ws = 1'b1;
            cmd_size = SIZE_W;
         end
         CMD_WRITE_WS_L: begin
            is_write_ws = 1'b1;
            cmd_size = SIZE_L;
         end
         CMD_FILL_B: is_fill = 1'b1;
         CMD_FILL_W: begin
            is_fill = 1'b1;
            cmd_size = SIZE_W;
         end
         CMD_FILL_L: begin
            is_fill = 1'b1;
            cmd_size = SIZE_L;
         end
         default: is_write = 1'b0;
      endcase
   end

   // Base holds the zeroed or original address. [RL10] [RL11] [RL13]
   assign next_fill_addr = prev_base + {{(ADDR_W-3){1'b0}}, size_bytes(prev_size)};

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         size <= SIZE_B;
         with_status <= 1'b0;
         count <= 2'h0;
         addr <= '0;
         data <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (rx_take && (is_write || is_write_ws)) begin
                  size <= cmd_size; // [RL1]
                  with_status <= is_write_ws;
                  count <= 2'h0;
                  data <= '0;
                  state <= ST_ADDR;
               end else if (rx_take && is_fill) begin
                  size <= cmd_size;
                  with_status <= 1'b0;
                  addr <= next_fill_addr; // [RL10]
                  count <= 2'h0;
                  data <= '0;
                  state <= ST_DATA;
               end
            end
            ST_ADDR: begin
               if (rx_take) begin
                  addr <= {addr[ADDR_W-BYTE_W-1:0], rx_byte}; // [RL2]
                  count <= count + 2'h1;
                  if (count == ADDR_LAST_BYTE) begin
                     count <= 2'h0;
                     state <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (rx_take) begin
                  data <= {data[DATA_W-BYTE_W-1:0], rx_byte}; // [RL3]
                  count <= count + 2'h1;
                  if ({1'b0, count} == (size_bytes(size) - 3'h1)) begin
                     count <= 2'h0;
                     state <= ST_BUS;
                  end
               end
            end
            ST_BUS: begin
               if (bus_end) begin
                  state <= with_status ? ST_SETTLE : ST_IDLE;
               end
            end
            ST_SETTLE: state <= ST_STATUS;
            ST_STATUS: begin
               if (status_ready) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Internal bus request
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_req <= 1'b0;
         bus_addr <= '0;
         bus_wdata <= '0;
         bus_be <= 4'h0;
      end else if ((state == ST_DATA) && rx_take
                   && ({1'b0, count} == (size_bytes(size) - 3'h1))) begin
         // Lanes load on the next cycle, after the last byte shifts in.
         bus_req <= 1'b1;
      end else if (state == ST_BUS) begin
         if (bus_end) begin
            bus_req <= 1'b0;
         end else begin
            bus_addr <= {addr[ADDR_W-1:2], lm.eff_low}; // [RL7] [RL8]
            bus_wdata <= lm.lanes; // [RL9]
            bus_be <= lm.be;
         end
      end
   end

   // ----------------------------------------------------------------
   // Fill address history
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_base <= '0;
         prev_size <= SIZE_B;
      end else if ((state == ST_BUS) && bus_end) begin
         prev_size <= size;
         // Longwords restart at the zeroed field; words keep the given address. [RL11] [RL12]
         prev_base <= (size == SIZE_L) ? {addr[ADDR_W-1:2], LOW_ZERO} : addr;
      end
   end

   // ----------------------------------------------------------------
   // Acknowledge and status return
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_pulse <= 1'b0;
      end else begin
         ack_pulse <= (state == ST_BUS) && bus_end && ack_enable; // [RL6]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_valid <= 1'b0;
         status_data <= 8'h00;
      end else if (state == ST_SETTLE) begin
         // Sampled one cycle after completion so the byte shows the write. [RL4]
         status_valid <= 1'b1;
         status_data <= debug_status_low_byte;
      end else if ((state == ST_STATUS) && status_ready) begin
         status_valid <= 1'b0; // [RL5]
      end
   end

   // ----------------------------------------------------------------
   // Stop mode clock gating
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         debug_serial_interface_clock_en <= 1'b1;
         bus_clock_en <= 1'b1;
         core_clock_en <= 1'b1;
      end else if (stop_mode) begin
         debug_serial_interface_clock_en <= debug_enable; // [RL15]
         bus_clock_en <= debug_enable && clocks_in_stop_select; // [RL14]
         core_clock_en <= debug_enable && clocks_in_stop_select; // [RL14]
      end else begin
         debug_serial_interface_clock_en <= 1'b1;
         bus_clock_en <= 1'b1;
         core_clock_en <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Program counter sample
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_sample <= '0;
      end else if (pc_write) begin
         pc_sample <= pc_write_value; // [RL16]
      end else if (!active_debug_mode) begin
         pc_sample <= next_pc; // [RL16]
      end
   end
endmodule // debug_mem_write

// File: design/debug_mem_pkg.sv
// Constants and types shared by the debug memory write block.
package debug_mem_pkg;

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_WRITE_B = 8'h11;
   localparam logic [7:0] CMD_WRITE_W = 8'h15;
   localparam logic [7:0] CMD_WRITE_L = 8'h19;
   localparam logic [7:0] CMD_WRITE_WS_B = 8'h13;
   localparam logic [7:0] CMD_WRITE_WS_W = 8'h17;
   localparam logic [7:0] CMD_WRITE_WS_L = 8'h1B;
   localparam logic [7:0] CMD_FILL_B = 8'h12;
   localparam logic [7:0] CMD_FILL_W = 8'h16;
   localparam logic [7:0] CMD_FILL_L = 8'h1A;

   // ----------------------------------------------------------------
   // Widths and counts
   // ----------------------------------------------------------------
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int FIFO_DEPTH = 16;
   localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
   localparam logic [1:0] LOW_ZERO = 2'h0;
   localparam logic [1:0] WORD_MISALIGNED_LOW = 2'h3;
   localparam logic [1:0] WORD_REALIGNED_LOW = 2'h2;

   typedef enum logic [1:0] {
      SIZE_B = 2'h0,
      SIZE_W = 2'h1,
      SIZE_L = 2'h2
   } size_t;

   // Number of bytes that an access of the given size moves.
   function automatic logic [2:0] size_bytes(input size_t s);
      case (s)
         SIZE_B: size_bytes = 3'h1;
         SIZE_W: size_bytes = 3'h2;
         default: size_bytes = 3'h4;
      endcase
   endfunction

endpackage

// File: design/lane_map_if.sv
// Carrier between the command engine and the byte lane mapper.
`timescale 1ns/1ps
interface lane_map_if;
   import debug_mem_pkg::*;
   size_t size;
   logic [1:0] low;
   logic [31:0] data;
   logic [31:0] lanes;
   logic [3:0] be;
   logic [1:0] eff_low;
   modport requester (output size, output low, output data,
                      input lanes, input be, input eff_low);
   modport mapper (input size, input low, input data,
                   output lanes, output be, output eff_low);
endinterface

// File: design/byte_fifo.sv
// Parameterised valid/ready FIFO held in flip-flops.
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // byte_fifo

// File: design/byte_lane_mapper.sv
// Places write data on the byte lanes of the internal bus.
`timescale 1ns/1ps
module byte_lane_mapper (
   lane_map_if.mapper lm
);
   import debug_mem_pkg::*;

   logic [1:0] first;
   logic [2:0] nbytes;
   logic [31:0] src;

   always_comb begin
      nbytes = size_bytes(lm.size);
      case (lm.size)
         SIZE_L: begin
            first = LOW_ZERO; // [RL7]
            src = lm.data;
         end
         SIZE_W: begin
            // Keeps a misaligned word inside one 4-byte field. [RL8]
            first = (lm.low == WORD_MISALIGNED_LOW) ? WORD_REALIGNED_LOW : lm.low;
            src = {lm.data[15:0], 16'h0000};
         end
         default: begin
            first = lm.low; // [RL9]
            src = {lm.data[7:0], 24'h000000};
         end
      endcase
      lm.eff_low = first;
      lm.lanes = 32'h00000000;
      lm.be = 4'h0;
      // Lane 00 is the most significant byte of the bus word.
      for (int i = 0; i < LANES; i++) begin
         if ((3'(i) >= {1'b0, first}) && (3'(i) < ({1'b0, first} + nbytes))) begin
            lm.be[LANES-1-i] = 1'b1;
            lm.lanes[(LANES-1-i)*BYTE_W +: BYTE_W] =
               src[(LANES-1-(i-int'(first)))*BYTE_W +: BYTE_W];
         end
      end
   end
endmodule // byte_lane_mapper

// File: verif/debug_host_model.sv
// Debug host model that sends link bytes and collects status bytes.
`timescale 1ns/1ps
module debug_host_model (
   input wire logic clk,
   input wire logic link_ready,
   input wire logic status_valid,
   input wire logic [7:0] status_data,
   output logic link_valid,
   output logic [7:0] link_data,
   output logic status_ready
);
   initial begin
      link_valid = 1'b0;
      link_data = 8'h00;
      status_ready = 1'b0;
   end

   // Sends the top n bytes of pk, most significant first.
   task automatic send(input logic [63:0] pk, input int n);
      @(posedge clk);
      for (int i = 0; i < n; i++) begin
         link_valid <= 1'b1;
         link_data <= pk[63 - 8 * i -: 8];
         @(negedge clk);
         while (link_ready !== 1'b1) @(negedge clk);
         @(posedge clk);
      end
      link_valid <= 1'b0;
   endtask

   // Valid rises only after the write, which covers the wait before status.
   task automatic take_status(output logic [7:0] b);
      @(negedge clk);
      while (status_valid !== 1'b1) @(negedge clk);
      b = status_data;
      @(posedge clk);
      status_ready <= 1'b1;
      @(posedge clk);
      status_ready <= 1'b0;
   endtask
endmodule // debug_host_model

// File: verif/debug_mem_write_assertions.sv
// Port-level checks for the debug memory write engine.
`timescale 1ns/1ps
module debug_mem_write_assertions (
   input wire logic clk,
   input wire logic nrst,
   input wire logic status_valid,
   input wire logic [7:0] status_data,
   input wire logic status_ready,
   input wire logic ack_enable,
   input wire logic ack_pulse,
   input wire logic bus_req,
   input wire logic [debug_mem_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [debug_mem_pkg::DATA_W-1:0] bus_wdata,
   input wire logic [3:0] bus_be,
   input wire logic bus_done,
   input wire logic bus_abort,
   input wire logic stop_mode,
   input wire logic debug_enable,
   input wire logic clocks_in_stop_select,
   input wire logic debug_serial_interface_clock_en,
   input wire logic bus_clock_en,
   input wire logic core_clock_en,
   input wire logic active_debug_mode,
   input wire logic [debug_mem_pkg::ADDR_W-1:0] next_pc,
   input wire logic pc_write,
   input wire logic [debug_mem_pkg::ADDR_W-1:0] pc_write_value,
   input wire logic [debug_mem_pkg::ADDR_W-1:0] pc_sample
);
   import debug_mem_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // ----------------------------------------------------------------
   // Bus access and lanes
   // ----------------------------------------------------------------
   // Lanes are judged from the second request cycle, once loaded.
   a_req_holds: assert property (bus_req && !bus_done && !bus_abort |=> bus_req)
      else $error("request dropped early");
   a_ack_follows: assert property (bus_req && (bus_done || bus_abort) && ack_enable
      |=> ack_pulse && !bus_req)
      else $error("acknowledge missing");
   a_ack_silent: assert property (bus_req && bus_done && !ack_enable |=> !ack_pulse)
      else $error("acknowledge while disabled");
   a_ack_cause: assert property (ack_pulse |-> $past(bus_done) || $past(bus_abort))
      else $error("stray acknowledge");
   a_long_aligned: assert property (bus_req && $past(bus_req) && bus_be == 4'hF
      |-> bus_addr[1:0] == 2'h0)
      else $error("longword misaligned");
   a_word_lanes: assert property (bus_req && $past(bus_req) && $countones(bus_be) == 2
      |-> bus_addr[1:0] != 2'h3 && bus_be == (4'hC >> bus_addr[1:0]))
      else $error("word lanes wrong");
   a_byte_lane: assert property (bus_req && $past(bus_req) && $countones(bus_be) == 1
      |-> bus_be == (4'h8 >> bus_addr[1:0]))
      else $error("byte lane wrong");
   a_idle_lanes: assert property (bus_req && $past(bus_req) |-> (bus_wdata &
      ~{{8{bus_be[3]}}, {8{bus_be[2]}}, {8{bus_be[1]}}, {8{bus_be[0]}}}) == 32'h0)
      else $error("data on a disabled lane");
   a_lanes_stable: assert property (bus_req && $past(bus_req) && !bus_done && !bus_abort
      |=> $stable(bus_addr) && $stable(bus_wdata) && $stable(bus_be))
      else $error("lanes changed");
   a_status_holds: assert property (status_valid && !status_ready
      |=> status_valid && $stable(status_data))
      else $error("status byte not held");

   // ----------------------------------------------------------------
   // Clocks and program counter
   // ----------------------------------------------------------------
   a_clk_all_on: assert property (stop_mode && debug_enable && clocks_in_stop_select
      |=> debug_serial_interface_clock_en && bus_clock_en && core_clock_en)
      else $error("clocks stopped");
   a_clk_serial_only: assert property (stop_mode && debug_enable && !clocks_in_stop_select
      |=> debug_serial_interface_clock_en && !bus_clock_en && !core_clock_en)
      else $error("wrong stop clocks");
   a_pc_written: assert property (pc_write |=> pc_sample == $past(pc_write_value))
      else $error("written pc not returned");
   a_pc_tracks: assert property (!pc_write && !active_debug_mode
      |=> pc_sample == $past(next_pc))
      else $error("pc sample not tracking");
endmodule // debug_mem_write_assertions

bind debug_mem_write debug_mem_write_assertions i_debug_mem_write_assertions (.clk, .nrst,
   .status_valid, .status_data, .status_ready, .ack_enable, .ack_pulse, .bus_req,
   .bus_addr, .bus_wdata, .bus_be, .bus_done, .bus_abort, .stop_mode, .debug_enable,
   .clocks_in_stop_select, .debug_serial_interface_clock_en, .bus_clock_en,
   .core_clock_en, .active_debug_mode, .next_pc, .pc_write, .pc_write_value, .pc_sample);

// File: verif/debug_mem_write_test.sv
// Self-checking bench for the debug memory write engine.
`timescale 1ns/1ps
module debug_mem_write_test;
   import debug_mem_pkg::*;
   logic clk, nrst, link_valid, link_ready, status_valid, status_ready, ack_enable, ack_pulse;
   logic bus_req, bus_done, bus_abort, stop_mode, debug_enable, clocks_in_stop_select;
   logic serial_en, bus_en, core_en, active_debug_mode, pc_write, resp_abort;
   logic [7:0] link_data, status_data, debug_status_low_byte, status_after, st;
   logic [23:0] bus_addr, next_pc, pc_write_value, pc_sample, got_addr;
   logic [31:0] bus_wdata, got_wdata;
   logic [3:0] bus_be, got_be;
   logic [7:0] ws_cmd [3] = '{CMD_WRITE_WS_B, CMD_WRITE_WS_W, CMD_WRITE_WS_L};
   int failures = 0, n_compared = 0, n_access = 0, n_ack = 0, cycles = 0, a0;

   debug_host_model i_debug_host_model (.clk, .link_ready, .status_valid, .status_data,
      .link_valid, .link_data, .status_ready);
   debug_mem_write i_debug_mem_write (.clk, .nrst, .link_valid, .link_data, .link_ready,
      .status_valid, .status_data, .status_ready, .ack_enable, .ack_pulse, .bus_req,
      .bus_addr, .bus_wdata, .bus_be, .bus_done, .bus_abort, .debug_status_low_byte,
      .stop_mode, .debug_enable, .clocks_in_stop_select,
      .debug_serial_interface_clock_en(serial_en), .bus_clock_en(bus_en), .core_clock_en(core_en),
      .active_debug_mode, .next_pc, .pc_write, .pc_write_value, .pc_sample);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Internal bus responder
   // ----------------------------------------------------------------
   // Done waits until the lanes have loaded.
   initial begin
      forever begin
         @(negedge clk);
         if (bus_req === 1'b1) begin
            @(negedge clk);
            got_addr = bus_addr;
            got_be = bus_be;
            got_wdata = bus_wdata;
            @(posedge clk);
            if (resp_abort) bus_abort <= 1'b1;
            else bus_done <= 1'b1;
            debug_status_low_byte <= status_after;
            @(posedge clk);
            bus_done <= 1'b0;
            bus_abort <= 1'b0;
            n_access++;
            @(negedge clk);
         end
      end
   end

   always @(negedge clk) if (ack_pulse === 1'b1) n_ack++;

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         failures++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s exp=%0h seen=%0h", name, exp, seen);
      end
   endtask

   // Fill codes carry no address bytes.
   task automatic access(input logic [7:0] cmd, input logic [23:0] addr, input int nb,
      input logic [31:0] data, input logic [23:0] exp_addr);
      logic [31:0] d;
      int start;
      d = data << (8 * (4 - nb));
      start = n_access;
      if (cmd[1:0] == 2'h2) i_debug_host_model.send({cmd, d, 24'h0}, 1 + nb);
      else i_debug_host_model.send({cmd, addr, d}, 4 + nb);
      for (int i = 0; i < 300 && n_access == start; i++) @(negedge clk);
      check("bus_access", n_access != start, 1'b1);
      check("bus_addr", got_addr, exp_addr);
      check("bus_be", got_be, (nb == 4) ? 4'hF : (nb == 2) ? (4'hC >> exp_addr[1:0])
         : (4'h8 >> exp_addr[1:0]));
      check("bus_wdata", got_wdata, d >> (8 * exp_addr[1:0]));
   endtask

   initial begin
      nrst = 1'b0;
      ack_enable = 1'b1;
      {bus_done, bus_abort, resp_abort, pc_write, active_debug_mode} = 5'h00;
      {stop_mode, debug_enable, clocks_in_stop_select} = 3'h0;
      {debug_status_low_byte, status_after} = 16'h0000;
      {next_pc, pc_write_value} = 48'h0;
      @(negedge clk);
      check("reset_outputs", {link_ready, bus_req, status_valid, pc_sample}, 27'h4000000);
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         access(CMD_WRITE_B, {22'h001000, k[1:0]}, 1, 32'hA5, {22'h001000, k[1:0]});
         access(CMD_WRITE_W, {22'h001040, k[1:0]}, 2, 32'hBEEF,
            {22'h001040, (k == 3) ? 2'h2 : k[1:0]});
      end
      access(CMD_WRITE_L, 24'h004003, 4, 32'h11223344, 24'h004000);
      access(CMD_FILL_L, 24'h0, 4, 32'h55667788, 24'h004004);
      access(CMD_FILL_W, 24'h0, 2, 32'h99AA, 24'h004008);
      access(CMD_FILL_W, 24'h0, 2, 32'hBBCC, 24'h00400A);
      access(CMD_FILL_B, 24'h0, 1, 32'hDD, 24'h00400C);
      access(CMD_FILL_W, 24'h0, 2, 32'hEEFF, 24'h00400D);
      access(CMD_FILL_W, 24'h0, 2, 32'h1357, 24'h00400E);
      access(CMD_FILL_W, 24'h0, 2, 32'h2468, 24'h004011);
      access(CMD_WRITE_W, 24'h00401F, 2, 32'hCAFE, 24'h00401E);
      access(CMD_FILL_W, 24'h0, 2, 32'hF00D, 24'h004021);
      for (int i = 0; i < 3; i++) begin
         status_after = {6'h10, i[1:0]};
         access(ws_cmd[i], 24'h005000, 1 << i, 32'h0A0B0C0D, 24'h005000);
         i_debug_host_model.take_status(st);
         check("status_data", st, {6'h10, i[1:0]});
      end
      // Untaken status stalls the engine, so the link buffer fills.
      access(CMD_WRITE_WS_B, 24'h005004, 1, 32'h77, 24'h005004);
      i_debug_host_model.send(64'h0, 8);
      i_debug_host_model.send(64'h0, 8);
      @(negedge clk);
      check("link_ready_full", link_ready, 1'b0);
      i_debug_host_model.take_status(st);
      repeat (24) @(negedge clk);
      check("link_ready_drained", link_ready, 1'b1);
      a0 = n_ack;
      resp_abort = 1'b1;
      access(CMD_WRITE_B, 24'h006000, 1, 32'h5A, 24'h006000);
      resp_abort = 1'b0;
      repeat (2) @(negedge clk);
      check("ack_after_abort", n_ack - a0, 1);
      @(posedge clk);
      ack_enable <= 1'b0;
      access(CMD_WRITE_B, 24'h006001, 1, 32'h5B, 24'h006001);
      repeat (2) @(negedge clk);
      check("ack_disabled", n_ack - a0, 1);
      for (int m = 0; m < 8; m++) begin
         @(posedge clk);
         {stop_mode, debug_enable, clocks_in_stop_select} <= m[2:0];
         repeat (2) @(negedge clk);
         check("clock_enables", {serial_en, bus_en, core_en},
            !m[2] ? 3'h7 : !m[1] ? 3'h0 : m[0] ? 3'h7 : 3'h4);
      end
      @(posedge clk);
      next_pc <= 24'h123456;
      stop_mode <= 1'b0;
      repeat (2) @(negedge clk);
      check("pc_track", pc_sample, 24'h123456);
      @(posedge clk);
      active_debug_mode <= 1'b1;
      @(posedge clk);
      next_pc <= 24'h654321;
      repeat (2) @(negedge clk);
      check("pc_hold", pc_sample, 24'h123456);
      @(posedge clk);
      pc_write <= 1'b1;
      pc_write_value <= 24'hABCDEF;
      @(posedge clk);
      pc_write <= 1'b0;
      repeat (2) @(negedge clk);
      check("pc_written", pc_sample, 24'hABCDEF);
      print_verdict();
   end
endmodule // debug_mem_write_test
